// [rtl/frame_pkg.sv]
// constants and types shared by the command frame slave and its fifo
// Operation
// (R1) command, type, bank, four value bytes MSB first
// (R2) serial frame: address, seven core bytes, checksum
// (R3) checksum is 8-bit sum of preceding bytes
// (R4) CAN frames drop address and checksum bytes
// (R5) command finishes before its single reply
// (R6) master awaits reply before next command
// (R7) drive bus only while sending solicited reply
// (R8) accept host and standalone program commands
// (R9) reply: addresses, status, command, value, checksum
// (R10) status codes 100,1,2,3,4,6
// (R11) drop foreign-address frames without reply
package frame_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and depths
  localparam int BYTE_W     = 8;                // stream byte width
  localparam int FIFO_DEPTH = 32;               // receive fifo words

  ////////////////////////////////////////////////////////////////////////////
  // command frame byte positions
  localparam logic [3:0] IDX_ADDR = 4'h0;       // module address
  localparam logic [3:0] IDX_CMD  = 4'h1;       // command number
  localparam logic [3:0] IDX_TYPE = 4'h2;       // type number
  localparam logic [3:0] IDX_BANK = 4'h3;       // motor or bank
  localparam logic [3:0] IDX_VAL  = 4'h4;       // value, msb byte first
  localparam logic [3:0] SER_LAST = 4'h8;       // last count, serial frame
  localparam logic [3:0] CAN_LAST = 4'h6;       // last count, can frame

  ////////////////////////////////////////////////////////////////////////////
  // reply byte positions and lengths
  localparam logic [3:0] RP_RADDR   = 4'h0;     // reply address
  localparam logic [3:0] RP_MADDR   = 4'h1;     // module address
  localparam logic [3:0] RP_STAT    = 4'h2;     // status
  localparam logic [3:0] RP_CMD     = 4'h3;     // command number
  localparam logic [3:0] RP_VAL     = 4'h4;     // first value byte
  localparam logic [3:0] RP_CSUM    = 4'h8;     // checksum
  localparam logic [3:0] RP_END_SER = 4'h9;     // past last serial byte
  localparam logic [3:0] RP_END_CAN = 4'h8;     // past last can byte
  localparam logic [3:0] LEN_SER    = 4'h9;     // serial reply bytes
  localparam logic [3:0] LEN_CAN    = 4'h7;     // can reply bytes

  ////////////////////////////////////////////////////////////////////////////
  // status codes
  localparam logic [7:0] ST_OK     = 8'h64;     // success
  localparam logic [7:0] ST_CSUM   = 8'h01;     // wrong checksum
  localparam logic [7:0] ST_BADCMD = 8'h02;     // invalid command
  localparam logic [7:0] ST_TYPE   = 8'h03;     // wrong type
  localparam logic [7:0] ST_VALUE  = 8'h04;     // invalid value
  localparam logic [7:0] ST_NA     = 8'h06;     // not available

  // executor result kinds
  localparam logic [2:0] RES_OK     = 3'h0;
  localparam logic [2:0] RES_BADCMD = 3'h1;
  localparam logic [2:0] RES_TYPE   = 3'h2;
  localparam logic [2:0] RES_VALUE  = 3'h3;
  localparam logic [2:0] RES_NA     = 3'h4;

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer phases
  typedef enum logic [1:0] {ST_RECV, ST_ISSUE, ST_EXEC, ST_REPLY} phase_e;

  // result kind to reply status, unknown kinds report not available
  function automatic logic [7:0] encodeStatus(input logic [2:0] res);
    logic [7:0] st;
    st = ST_NA;
    unique case (res)
      RES_OK:     st = ST_OK;
      RES_BADCMD: st = ST_BADCMD;
      RES_TYPE:   st = ST_TYPE;
      RES_VALUE:  st = ST_VALUE;
      default:    st = ST_NA;
    endcase
    return st;
  endfunction

endpackage

// [rtl/byte_fifo.sv]
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // filling side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // draining side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(DEPTH);                 // pointer width
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);     // full count

  logic [W-1:0] mem [0:DEPTH-1];                     // storage
  logic [AW-1:0] wrPtr_r;                            // write pointer
  logic [AW-1:0] rdPtr_r;                            // read pointer
  logic [AW:0]   count_r;                            // words held
  logic [AW:0]   count_nxt;                          // next count
  logic          wrEn;                               // push this cycle
  logic          rdEn;                               // pop this cycle

  // handshake decode and next count
  always_comb
  begin
    wrEn      = inValid && inReady;
    rdEn      = outValid && outReady;
    count_nxt = count_r;
    if (wrEn && !rdEn)
      count_nxt = count_r + 1'b1;
    else if (rdEn && !wrEn)
      count_nxt = count_r - 1'b1;
    outValid = (count_r != '0);
    outData  = mem[rdPtr_r];
  end

  // storage write, no reset needed
  always_ff @(posedge clk)
  begin
    if (wrEn)
      mem[wrPtr_r] <= inData;
  end

  // pointers, count and registered ready
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      inReady <= 1'b0;
    end
    else
    begin
      if (wrEn)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (rdEn)
        rdPtr_r <= rdPtr_r + 1'b1;
      count_r <= count_nxt;
      inReady <= (count_nxt != FULL);
    end
  end
endmodule

// [rtl/serial_command_frame_slave.sv]
// command frame receiver, executor handshake and reply sender
`timescale 1ns/100ps
module serial_command_frame_slave (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // configuration
  input  wire logic        canModePin,
  input  wire logic [7:0]  moduleAddr,
  input  wire logic [7:0]  replyAddr,
  // received byte stream
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  output logic             rxReady,
  // reply byte stream and line driver
  output logic             txValid_r,
  output logic [7:0]       txData_r,
  input  wire logic        txReady,
  output logic             txDriveEn_r,
  // standalone program commands
  input  wire logic        progValid,
  input  wire logic [7:0]  progCode,
  input  wire logic [7:0]  progType,
  input  wire logic [7:0]  progBank,
  input  wire logic [31:0] progValue,
  output logic             progReady_r,
  output logic             progDone_r,
  output logic [7:0]       progStatus_r,
  output logic [31:0]      progResult_r,
  // command executor
  output logic             cmdValid_r,
  output logic             cmdFromProg_r,
  output logic [7:0]       cmdCode_r,
  output logic [7:0]       cmdType_r,
  output logic [7:0]       cmdBank_r,
  output logic [31:0]      cmdValue_r,
  input  wire logic        execDone,
  input  wire logic [2:0]  execResult,
  input  wire logic [31:0] execValue
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic              canS1_r;          // mode strap, first stage
  logic              canS2_r;          // mode strap, synchronised
  frame_pkg::phase_e state_r;          // sequencer phase
  logic [3:0]        rxCnt_r;          // bytes of frame so far
  logic [7:0]        rxSum_r;          // running frame sum
  logic [7:0]        frame_r [0:8];    // assembled frame
  logic              fromProg_r;       // pending command source
  logic [7:0]        repStatus_r;      // reply status
  logic [7:0]        repCmd_r;         // reply command number
  logic [31:0]       repValue_r;       // reply value
  logic [3:0]        txPos_r;          // next reply position
  logic [7:0]        txSum_r;          // sum of loaded bytes
  logic [3:0]        txCount_r;        // fired bytes, checking only
  logic [7:0]        firedSum_r;       // fired sum, checking only
  logic              fifoValid;        // byte waiting
  logic [7:0]        fifoData;         // waiting byte
  logic              popByte;          // consume a byte
  logic              frameDone;        // last byte of frame now
  logic              addrOk;           // address matches
  logic              csumOk;           // checksum matches
  logic              progTake;         // program command taken
  logic              execTake;         // executor finished
  logic              txFire;           // reply byte accepted
  logic              txStep;           // tx register may advance
  logic              txEnd;            // all reply bytes loaded
  logic [3:0]        lastIdx;          // last count for mode
  logic [3:0]        storeIdx;         // frame slot for byte
  logic [7:0]        txByte;           // byte for txPos_r

  // reply byte at a position, value msb first
  function automatic logic [7:0] replyByte(input logic [3:0] pos, input logic [7:0] st,
                                           input logic [7:0] cm, input logic [31:0] v,
                                           input logic [7:0] ra, input logic [7:0] ma,
                                           input logic [7:0] cs);
    logic [7:0] b;
    b = cs;
    case (pos)
      frame_pkg::RP_RADDR:       b = ra;
      frame_pkg::RP_MADDR:       b = ma;
      frame_pkg::RP_STAT:        b = st;
      frame_pkg::RP_CMD:         b = cm;
      frame_pkg::RP_VAL:         b = v[31:24];
      frame_pkg::RP_VAL + 4'h1:  b = v[23:16];
      frame_pkg::RP_VAL + 4'h2:  b = v[15:8];
      frame_pkg::RP_VAL + 4'h3:  b = v[7:0];
      default:                   b = cs;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive fifo, drained only while listening so it back-pressures
  byte_fifo #(.W(frame_pkg::BYTE_W), .DEPTH(frame_pkg::FIFO_DEPTH)) rxFifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (rxValid),
    .inData   (rxData),
    .inReady  (rxReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (popByte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  always_comb
  begin
    lastIdx   = canS2_r ? frame_pkg::CAN_LAST : frame_pkg::SER_LAST;  // [R2] [R4]
    storeIdx  = canS2_r ? rxCnt_r + 4'h1 : rxCnt_r;                  // [R4]
    progTake  = progValid && progReady_r && (state_r == frame_pkg::ST_RECV);  // [R8]
    popByte   = fifoValid && (state_r == frame_pkg::ST_RECV) && !progTake;
    frameDone = popByte && (rxCnt_r == lastIdx);
    addrOk    = (frame_r[frame_pkg::IDX_ADDR] == moduleAddr);
    csumOk    = (fifoData == rxSum_r);                                // [R3]
    execTake  = execDone && (state_r == frame_pkg::ST_EXEC);
    txFire    = txValid_r && txReady;
    txStep    = (state_r == frame_pkg::ST_REPLY) && (!txValid_r || txReady);
    txEnd     = (txPos_r == (canS2_r ? frame_pkg::RP_END_CAN : frame_pkg::RP_END_SER));
    txByte    = replyByte(txPos_r, repStatus_r, repCmd_r, repValue_r, replyAddr,
                          moduleAddr, txSum_r);                       // [R9]
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode strap synchroniser
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      canS1_r <= 1'b0;
      canS2_r <= 1'b0;
    end
    else
    begin
      canS1_r <= canModePin;
      canS2_r <= canS1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_r <= frame_pkg::ST_RECV;
    else
    begin
      unique case (state_r)
        frame_pkg::ST_RECV:
        begin
          if (progTake)
            state_r <= frame_pkg::ST_ISSUE;                           // [R8]
          else if (frameDone && canS2_r)
            state_r <= frame_pkg::ST_ISSUE;                           // [R4]
          else if (frameDone && addrOk && !csumOk)
            state_r <= frame_pkg::ST_REPLY;                           // [R3]
          else if (frameDone && addrOk)
            state_r <= frame_pkg::ST_ISSUE;                           // [R11]
        end
        frame_pkg::ST_ISSUE:
          state_r <= frame_pkg::ST_EXEC;
        frame_pkg::ST_EXEC:
        begin
          // reply only after the command has completed
          if (execTake)
            state_r <= fromProg_r ? frame_pkg::ST_RECV : frame_pkg::ST_REPLY;  // [R5] [R7]
        end
        frame_pkg::ST_REPLY:
        begin
          if (txFire && txEnd)
            state_r <= frame_pkg::ST_RECV;                            // [R7]
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame assembly and running checksum
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rxCnt_r    <= 4'h0;
      rxSum_r    <= frame_pkg::RST_BYTE;
      fromProg_r <= 1'b0;
    end
    else if (popByte)
    begin
      frame_r[storeIdx] <= fifoData;                                  // [R1] [R2]
      rxSum_r <= (rxCnt_r == 4'h0) ? fifoData : rxSum_r + fifoData;   // [R3]
      rxCnt_r <= frameDone ? 4'h0 : rxCnt_r + 4'h1;
      fromProg_r <= 1'b0;
    end
    else if (progTake)
    begin
      // program command fills the core slots like a host frame
      frame_r[frame_pkg::IDX_CMD]         <= progCode;                // [R8]
      frame_r[frame_pkg::IDX_TYPE]        <= progType;
      frame_r[frame_pkg::IDX_BANK]        <= progBank;
      frame_r[frame_pkg::IDX_VAL]         <= progValue[31:24];
      frame_r[frame_pkg::IDX_VAL + 4'h1]  <= progValue[23:16];
      frame_r[frame_pkg::IDX_VAL + 4'h2]  <= progValue[15:8];
      frame_r[frame_pkg::IDX_VAL + 4'h3]  <= progValue[7:0];
      fromProg_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command issue to executor
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmdValid_r    <= 1'b0;
      cmdFromProg_r <= 1'b0;
      cmdCode_r     <= frame_pkg::RST_BYTE;
      cmdType_r     <= frame_pkg::RST_BYTE;
      cmdBank_r     <= frame_pkg::RST_BYTE;
      cmdValue_r    <= frame_pkg::RST_WORD;
    end
    else
    begin
      cmdValid_r <= (state_r == frame_pkg::ST_ISSUE);
      if (state_r == frame_pkg::ST_ISSUE)
      begin
        cmdFromProg_r <= fromProg_r;
        cmdCode_r     <= frame_r[frame_pkg::IDX_CMD];                 // [R1]
        cmdType_r     <= frame_r[frame_pkg::IDX_TYPE];
        cmdBank_r     <= frame_r[frame_pkg::IDX_BANK];
        cmdValue_r    <= {frame_r[frame_pkg::IDX_VAL], frame_r[frame_pkg::IDX_VAL + 4'h1],
                          frame_r[frame_pkg::IDX_VAL + 4'h2], frame_r[frame_pkg::IDX_VAL + 4'h3]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply contents
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      repStatus_r <= frame_pkg::RST_BYTE;
      repCmd_r    <= frame_pkg::RST_BYTE;
      repValue_r  <= frame_pkg::RST_WORD;
    end
    else if ((state_r == frame_pkg::ST_RECV) && frameDone && !canS2_r && addrOk && !csumOk)
    begin
      repStatus_r <= frame_pkg::ST_CSUM;                              // [R3] [R10]
      repCmd_r    <= frame_r[frame_pkg::IDX_CMD];
      repValue_r  <= frame_pkg::RST_WORD;
    end
    else if (execTake && !fromProg_r)
    begin
      repStatus_r <= frame_pkg::encodeStatus(execResult);             // [R10]
      repCmd_r    <= cmdCode_r;
      repValue_r  <= execValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program handshake and result, never sent on the bus
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      progReady_r  <= 1'b0;
      progDone_r   <= 1'b0;
      progStatus_r <= frame_pkg::RST_BYTE;
      progResult_r <= frame_pkg::RST_WORD;
    end
    else
    begin
      // only between host frames, a program command taken wins over a host byte in that cycle
      progReady_r <= (state_r == frame_pkg::ST_RECV) && (rxCnt_r == 4'h0) && !fifoValid
                     && !progTake;                                    // [R8]
      progDone_r  <= execTake && fromProg_r;
      if (execTake && fromProg_r)
      begin
        progStatus_r <= frame_pkg::encodeStatus(execResult);          // [R10]
        progResult_r <= execValue;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply transmitter and line driver enable
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txValid_r   <= 1'b0;
      txData_r    <= frame_pkg::RST_BYTE;
      txPos_r     <= frame_pkg::RP_RADDR;
      txSum_r     <= frame_pkg::RST_BYTE;
      txDriveEn_r <= 1'b0;
    end
    else if (state_r != frame_pkg::ST_REPLY)
    begin
      txValid_r   <= 1'b0;
      txPos_r     <= canS2_r ? frame_pkg::RP_MADDR : frame_pkg::RP_RADDR;  // [R4]
      txSum_r     <= frame_pkg::RST_BYTE;
      txDriveEn_r <= 1'b0;                                            // [R7]
    end
    else
    begin
      txDriveEn_r <= !(txFire && txEnd);                              // [R7]
      if (txStep)
      begin
        if (txValid_r && txEnd)
          txValid_r <= 1'b0;
        else
        begin
          txData_r  <= txByte;                                        // [R9]
          txValid_r <= 1'b1;
          txSum_r   <= txSum_r + txByte;                              // [R3]
          txPos_r   <= txPos_r + 4'h1;
        end
      end
    end
  end

  // helper counters for the checks below
  always_ff @(posedge clk)
  begin
    if (sys_rst || (state_r != frame_pkg::ST_REPLY))
    begin
      txCount_r  <= 4'h0;
      firedSum_r <= frame_pkg::RST_BYTE;
    end
    else if (txFire)
    begin
      txCount_r  <= txCount_r + 4'h1;
      firedSum_r <= firedSum_r + txData_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_drive_covers_tx: assert property (txValid_r |-> txDriveEn_r)  // [R7]
    else $error("reply byte offered without driver enabled");
  chk_drive_only_reply: assert property (txDriveEn_r |-> state_r == frame_pkg::ST_REPLY)  // [R7]
    else $error("line driven outside reply");
  chk_reply_after_exec: assert property (execTake && !fromProg_r  // [R5]
                                         |=> state_r == frame_pkg::ST_REPLY
                                         ##1 txValid_r && txDriveEn_r)
    else $error("reply did not follow completed command");
  chk_issue_once: assert property (cmdValid_r  // [R5]
                                   |-> state_r == frame_pkg::ST_EXEC ##1 !cmdValid_r)
    else $error("command issued outside execute phase");
  chk_csum_status: assert property (frameDone && !canS2_r && addrOk && !csumOk  // [R3]
                                    |=> repStatus_r == frame_pkg::ST_CSUM)
    else $error("bad checksum not reported as status 1");
  chk_addr_drop: assert property (frameDone && !canS2_r && !addrOk  // [R11]
                                  |=> state_r == frame_pkg::ST_RECV [*2] ##0 !txDriveEn_r)
    else $error("foreign frame was answered");
  chk_reply_length: assert property (txFire && txEnd  // [R2]
                                     |-> (txCount_r + 4'h1) ==
                                     (canS2_r ? frame_pkg::LEN_CAN : frame_pkg::LEN_SER))
    else $error("reply length wrong for link mode");
  chk_first_byte: assert property (txFire && txCount_r == 4'h0 && !canS2_r  // [R9]
                                   |-> txData_r == replyAddr)
    else $error("reply does not start with reply address");
  chk_tx_checksum: assert property (txFire && txEnd && !canS2_r  // [R3]
                                    |-> txData_r == firedSum_r)
    else $error("reply checksum not sum of preceding bytes");
  chk_prog_silent: assert property (execTake && fromProg_r  // [R8]
                                    |=> progDone_r && !txDriveEn_r
                                    && state_r == frame_pkg::ST_RECV)
    else $error("program command reached the bus");
  chk_value_order: assert property (cmdValid_r  // [R1]
                                    |-> cmdValue_r[31:24] == frame_r[frame_pkg::IDX_VAL]
                                    && cmdCode_r == frame_r[frame_pkg::IDX_CMD])
    else $error("command fields not taken msb first");
  chk_status_code: assert property (execTake && !fromProg_r  // [R10]
                                    && execResult == frame_pkg::RES_OK
                                    |=> repStatus_r == 8'h64)
    else $error("success status not 100");
endmodule

// [dv/host_model.sv]
// host side model: sends command bytes and collects reply bytes
`timescale 1ns/100ps
module host_model (
  // clock
  input  wire logic       clk,
  // command stream to the slave
  output logic            rxValid,
  output logic [7:0]      rxData,
  input  wire logic       rxReady,
  // reply stream from the slave
  input  wire logic       txValid_r,
  input  wire logic [7:0] txData_r,
  output logic            txReady,
  input  wire logic       txDriveEn_r
);
  logic [7:0] rep [$];      // captured reply bytes
  int         badDrive = 0; // bytes offered with the driver off
  logic       slow     = 0; // stall every other cycle
  initial
  begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    txReady = 1'b1;
  end
  // one byte, held until taken; line shows inverse once released
  task automatic sendByte(input logic [7:0] b);
    @(posedge clk);
    rxValid <= 1'b1;
    rxData  <= b;
    @(negedge clk);
    while (rxReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    rxValid <= 1'b0;
    rxData  <= ~b;
  endtask
  // reply sink, optionally stalling
  always @(posedge clk)
  begin
    txReady <= slow ? ~txReady : 1'b1;
    if (txValid_r && txReady) rep.push_back(txData_r);
    if (txValid_r && !txDriveEn_r) badDrive++;
  end
endmodule

// [dv/serial_command_frame_slave_test.sv]
// self-checking bench for the command frame slave
`timescale 1ns/100ps
module serial_command_frame_slave_test;
  logic        clk, sys_rst, canModePin, rxValid, rxReady, txValid_r, txReady, txDriveEn_r;
  logic        progValid, progReady_r, progDone_r, cmdValid_r, cmdFromProg_r, execDone;
  logic [7:0]  moduleAddr, replyAddr, rxData, txData_r, progCode, progType, progBank;
  logic [7:0]  progStatus_r, cmdCode_r, cmdType_r, cmdBank_r;
  logic [31:0] progValue, progResult_r, cmdValue_r, execValue;
  logic [2:0]  execResult;
  int          mismatches = 0, compares = 0, cmdCnt = 0;
  serial_command_frame_slave i_serial_command_frame_slave (.*);
  host_model i_host_model (.*);
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // executor: answers one cycle after each command
  always @(posedge clk)
  begin
    execDone <= cmdValid_r;
    if (cmdValid_r) cmdCnt++;
  end
  task automatic check(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // frame with checksum, skewed by bad; can mode drops ends
  task automatic sendCmd(input logic [7:0] a, c, input logic [31:0] v, input logic [7:0] bad);
    logic [7:0] f [0:8];
    f = '{a, c, 8'h04, 8'h01, v[31:24], v[23:16], v[15:8], v[7:0], bad};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    for (int i = canModePin; i < 9 - canModePin; i++) i_host_model.sendByte(f[i]);
  endtask
  // waits for a whole reply and compares every byte
  task automatic checkReply(input int b, input logic [7:0] st, c, input logic [31:0] v);
    logic [7:0] e [0:8];
    int n;
    n = canModePin ? 7 : 9;
    e = '{replyAddr, moduleAddr, st, c, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) e[8] += e[i];
    for (int i = 0; i < 400 && i_host_model.rep.size() < b + n; i++) @(posedge clk);
    for (int i = 0; i < n; i++) check("reply", e[i + canModePin], i_host_model.rep[b + i]);
    repeat (20) @(posedge clk);
    check("reply length", b + n, i_host_model.rep.size());
  endtask
  task automatic testStatus();
    logic [7:0] st [0:5];
    // result 5 lies outside the defined kinds and reports not available
    st = '{frame_pkg::ST_OK, frame_pkg::ST_BADCMD, frame_pkg::ST_TYPE, frame_pkg::ST_VALUE,
           frame_pkg::ST_NA, frame_pkg::ST_NA};
    for (int r = 0; r < 6; r++)
    begin
      @(posedge clk);
      execResult <= r;
      execValue <= 32'ha1b2_c3d4 + r;
      i_host_model.slow <= (r == 2);
      sendCmd(moduleAddr, 8'h05 + r, 32'h1234_5678 + r, 0);
      checkReply(i_host_model.rep.size(), st[r], 8'h05 + r, 32'ha1b2_c3d4 + r);
      check("cmdValue", 32'h1234_5678 + r, cmdValue_r);
      check("cmdBank", 8'h01, cmdBank_r);
      check("cmdType", 8'h04, cmdType_r);
      check("cmdCode", 8'h05 + r, cmdCode_r);
      check("cmdFromProg", 0, cmdFromProg_r);
    end
  endtask
  task automatic testBadSum();
    int c;
    c = cmdCnt;
    sendCmd(moduleAddr, 8'h06, 32'h0000_00ff, 8'h01);
    checkReply(i_host_model.rep.size(), frame_pkg::ST_CSUM, 8'h06, 0);
    check("executed", c, cmdCnt);
  endtask
  task automatic testForeign();
    int b, c;
    b = i_host_model.rep.size();
    c = cmdCnt;
    sendCmd(moduleAddr + 1, 8'h06, 32'h5, 0);
    repeat (60) @(posedge clk);
    check("foreign reply", b, i_host_model.rep.size());
    check("foreign executed", c, cmdCnt);
    check("foreign drive", 0, txDriveEn_r);
  endtask
  task automatic testProg();
    int b;
    b = i_host_model.rep.size();
    @(posedge clk);
    execResult <= frame_pkg::RES_TYPE;
    execValue <= 32'h0bad_f00d;
    progValid <= 1;
    @(negedge clk);
    while (progReady_r !== 1'b1) @(negedge clk);
    @(posedge clk);
    progValid <= 0;
    for (int i = 0; i < 50 && progDone_r !== 1'b1; i++) @(negedge clk);
    check("progStatus", frame_pkg::ST_TYPE, progStatus_r);
    check("progResult", 32'h0bad_f00d, progResult_r);
    check("cmdFromProg", 1, cmdFromProg_r);
    check("cmdValue", 32'h8765_4321, cmdValue_r);
    check("progDone", 1, progDone_r);
    check("cmdCode", progCode, cmdCode_r);
    check("cmdType", progType, cmdType_r);
    check("cmdBank", progBank, cmdBank_r);
    check("prog drive", 0, txDriveEn_r);
    repeat (20) @(posedge clk);
    check("prog bus traffic", b, i_host_model.rep.size());
  endtask
  task automatic testCan();
    @(posedge clk);
    canModePin <= 1;
    execResult <= frame_pkg::RES_OK;
    repeat (6) @(posedge clk);
    sendCmd(8'h00, 8'h0a, 32'hfeed_0042, 0);
    checkReply(i_host_model.rep.size(), frame_pkg::ST_OK, 8'h0a, 32'h0bad_f00d);
    check("cmdValue", 32'hfeed_0042, cmdValue_r);
  endtask
  initial
  begin
    {sys_rst, canModePin, progValid} = 3'b100;
    {moduleAddr, replyAddr, progCode, progType, progBank} = 40'h2a_02_0b_0c_0d;
    {progValue, execValue, execResult} = {32'h8765_4321, 35'h0};
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    repeat (3) @(posedge clk);
    testForeign();
    testStatus();
    testBadSum();
    testProg();
    testCan();
    check("drive enable", 0, i_host_model.badDrive);
    give_verdict();
  end
  initial
  begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule
